// ===== src/sensor_regs_cfg.svh
// Purpose: Offsets, field positions, reset values and bus constants of the sensor register block
// Assumes: Byte-wide registers reached over the two-wire serial port
// Notes:   Definitions only
`ifndef SENSOR_REGS_CFG_SVH
`define SENSOR_REGS_CFG_SVH

`define OFS_TEMP_LOW        8'h00
`define OFS_TEMP_HIGH       8'h01
`define OFS_HUM_LOW         8'h02
`define OFS_HUM_HIGH        8'h03
`define OFS_EVENT_FLAGS     8'h04
`define OFS_PEAK_TEMP       8'h05
`define OFS_PEAK_HUM        8'h06
`define OFS_PIN_ENABLES     8'h07
`define OFS_LAST_MAPPED     8'h07

`define BIT_DONE            7
`define BIT_TEMP_HIGH       6
`define BIT_TEMP_LOW        5
`define BIT_HUM_HIGH        4
`define BIT_HUM_LOW         3
`define FLAG_MSB            7
`define FLAG_LSB            3

`define RST_BYTE            8'h00
`define RST_WORD            16'h0000
`define RST_FLAGS           5'h00

`define TARGET_ADDR_HI      6'h20
`define BIT_COUNT_FULL      4'h8

`endif

// ===== src/sensor_regs_pkg.sv
// Purpose: Types shared by the sensor register block
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Serial port state machine encoding
package sensor_regs_pkg;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ADDR    = 3'b001,
      ST_ADDR_AK = 3'b010,
      ST_WR_BYTE = 3'b011,
      ST_WR_AK   = 3'b100,
      ST_RD_BYTE = 3'b101,
      ST_RD_AK   = 3'b110
   } port_state_e;

   typedef logic [7:0] byte_t;

endpackage

// ===== src/line_sampler.sv
// Purpose: Synchronise the serial pins and find clock edges, start and stop
// Assumes: Pins come from outside the mclk domain
// Notes:   Only second-stage values feed the detectors
`timescale 1ns/1ns
module line_sampler (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Raw pins
   input  wire logic scl_pin,
   input  wire logic sda_pin,
   input  wire logic addr_pin,
   // Clean events and levels
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start_det,
   output logic      stop_det,
   output logic      sda_level,
   output logic      addr_level
);

   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic       scl_old_reg;
   logic       sda_old_reg;

   // Two-stage synchronisers, idle high
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         meta_reg <= 3'h7;
         sync_reg <= 3'h7;
      end else begin
         meta_reg <= {addr_pin, sda_pin, scl_pin};
         sync_reg <= meta_reg;
      end
   end

   // Previous clean levels for edge finding
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         scl_old_reg <= 1'b1;
         sda_old_reg <= 1'b1;
      end else begin
         scl_old_reg <= sync_reg[0];
         sda_old_reg <= sync_reg[1];
      end
   end

   // Edges and bus conditions
   assign scl_rise   = sync_reg[0] & ~scl_old_reg;
   assign scl_fall   = ~sync_reg[0] & scl_old_reg;
   assign start_det  = sync_reg[0] & scl_old_reg & sda_old_reg & ~sync_reg[1];
   assign stop_det   = sync_reg[0] & scl_old_reg & ~sda_old_reg & sync_reg[1];
   assign sda_level  = sync_reg[1];
   assign addr_level = sync_reg[2];

endmodule // line_sampler

// ===== src/sensor_regs.sv
// Purpose: Humidity result, event flags, peak detectors and event pin enables behind a two-wire port
// Assumes: Measurement engine on mclk gives results and a done pulse
// Notes:   Threshold values and global pin enable come from configuration logic outside
`timescale 1ns/1ns
`include "sensor_regs_cfg.svh"

// What this block does
// - Humidity low byte 0x02, high 0x03
// - Humidity code is percent RH times 65536/100
// - Humidity bytes read-only, zero after reset
// - Flags in bits 7..3, low bits read zero
// - Done flag set on conversion, cleared reading 0x00-0x04
// - Threshold flags cleared by reading 0x04
// - Threshold crossing sets its flag
// - Enables never change flag contents
// - Enable register bits 7..3, read-write, reset zero
// - Only enabled sources reach event pin
// - Per-source enables need global pin enable
// - Peak temperature kept at 0x05, one-shot only
// - Peak temperature code is upper result byte
// - Peak humidity kept at 0x06, one-shot only
// - Peak humidity code is upper result byte
// - Reads use last written pointer
// - Pointer advances after each data byte written and each read byte the host acknowledges
// - NACK read-only data and unused pointers
module sensor_regs (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   // Serial port pins
   input  wire logic                 scl_pin,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe_n,
   input  wire logic                 addr_pin,
   // Measurement engine
   input  wire logic                 conv_done,
   input  wire logic                 temp_valid,
   input  wire logic                 hum_valid,
   input  wire logic [15:0]          temp_result,
   input  wire logic [15:0]          hum_result,
   input  wire logic                 one_shot_mode,
   input  wire logic                 soft_reset,
   // Configuration held elsewhere
   input  wire sensor_regs_pkg::byte_t temp_thr_low,
   input  wire sensor_regs_pkg::byte_t temp_thr_high,
   input  wire sensor_regs_pkg::byte_t hum_thr_low,
   input  wire sensor_regs_pkg::byte_t hum_thr_high,
   input  wire logic                 event_pin_global_en,
   // Event output
   output logic                      event_output_pin
);
   import sensor_regs_pkg::*;

   port_state_e state_reg;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic        sda_level;
   logic        addr_level;
   logic [3:0]  bit_cnt_reg;
   byte_t       shift_reg;
   byte_t       tx_reg;
   byte_t       ptr_reg;
   logic        first_reg;
   logic        ack_reg;
   logic        drive_reg;
   logic        host_ack_reg;
   logic        rd_load;
   logic        wr_take;
   byte_t       rx_byte;
   byte_t       rd_data;
   logic [15:0] hum_reg;
   logic [`FLAG_MSB:`FLAG_LSB] flag_reg;
   logic [`FLAG_MSB:`FLAG_LSB] en_reg;
   logic [`FLAG_MSB:`FLAG_LSB] flag_set;
   logic [`FLAG_MSB:`FLAG_LSB] flag_clr;
   byte_t       peak_temp_reg;
   byte_t       peak_hum_reg;
   logic        irq_reg;
   logic        clear_all;

   // Registers that a pointer byte may select
   function automatic logic is_mapped(input byte_t a);
      is_mapped = (a <= `OFS_LAST_MAPPED);
   endfunction

   line_sampler u_sampler (
      .mclk       (mclk),
      .sys_rst    (sys_rst),
      .scl_pin    (scl_pin),
      .sda_pin    (sda_in),
      .addr_pin   (addr_pin),
      .scl_rise   (scl_rise),
      .scl_fall   (scl_fall),
      .start_det  (start_det),
      .stop_det   (stop_det),
      .sda_level  (sda_level),
      .addr_level (addr_level)
   );

   // Open drain: only ever pull low
   assign sda_out   = 1'b0;
   assign sda_oe_n  = ~drive_reg;
   assign rx_byte   = shift_reg;
   assign clear_all = soft_reset;

   // Byte sent for the current pointer
   always_comb begin
      unique case (ptr_reg)
         `OFS_TEMP_LOW:    rd_data = temp_result[7:0];
         `OFS_TEMP_HIGH:   rd_data = temp_result[15:8];
         `OFS_HUM_LOW:     rd_data = hum_reg[7:0];
         `OFS_HUM_HIGH:    rd_data = hum_reg[15:8];
         `OFS_EVENT_FLAGS: rd_data = {flag_reg, 3'h0};
         `OFS_PEAK_TEMP:   rd_data = peak_temp_reg;
         `OFS_PEAK_HUM:    rd_data = peak_hum_reg;
         `OFS_PIN_ENABLES: rd_data = {en_reg, 3'h0};
         default:          rd_data = `RST_BYTE;
      endcase
   end

   // Byte load for transmit, and write byte taken on the fall of the eighth clock
   assign rd_load = scl_fall & ((state_reg == ST_ADDR_AK & shift_reg[0] & ack_reg)
                    | (state_reg == ST_RD_AK & host_ack_reg));
   assign wr_take = scl_fall & (state_reg == ST_WR_BYTE) & (bit_cnt_reg == `BIT_COUNT_FULL);

   // Port state machine
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
      end else if (start_det) begin
         state_reg <= ST_ADDR;
      end else if (stop_det) begin
         state_reg <= ST_IDLE;
      end else if (scl_fall) begin
         unique case (state_reg)
            ST_IDLE:    state_reg <= ST_IDLE;
            ST_ADDR: begin
               if (bit_cnt_reg == `BIT_COUNT_FULL) begin
                  state_reg <= (shift_reg[7:1] == {`TARGET_ADDR_HI, addr_level}) ? ST_ADDR_AK : ST_IDLE;
               end
            end
            ST_ADDR_AK: state_reg <= shift_reg[0] ? ST_RD_BYTE : ST_WR_BYTE;
            ST_WR_BYTE: begin
               if (bit_cnt_reg == `BIT_COUNT_FULL) begin
                  state_reg <= ST_WR_AK;
               end
            end
            ST_WR_AK:   state_reg <= (first_reg & ~ack_reg) ? ST_IDLE : ST_WR_BYTE;
            ST_RD_BYTE: begin
               if (bit_cnt_reg == `BIT_COUNT_FULL) begin
                  state_reg <= ST_RD_AK;
               end
            end
            ST_RD_AK:   state_reg <= host_ack_reg ? ST_RD_BYTE : ST_IDLE;
            default:    state_reg <= ST_IDLE;
         endcase
      end
   end

   // Bit counter and receive shifter
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bit_cnt_reg <= 4'h0;
         shift_reg   <= `RST_BYTE;
      end else if (start_det || (scl_fall && bit_cnt_reg == `BIT_COUNT_FULL)) begin
         bit_cnt_reg <= 4'h0;
      end else if (scl_rise && state_reg inside {ST_ADDR, ST_WR_BYTE, ST_RD_BYTE}) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         shift_reg   <= {shift_reg[6:0], sda_level};
      end
   end

   // Host acknowledge sampled on the ninth read clock
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         host_ack_reg <= 1'b0;
      end else if (scl_rise && state_reg == ST_RD_AK) begin
         host_ack_reg <= ~sda_level;
      end
   end

   // Acknowledge decision for address, pointer and data bytes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_reg   <= 1'b0;
         first_reg <= 1'b0;
      end else if (scl_fall && state_reg == ST_ADDR && bit_cnt_reg == `BIT_COUNT_FULL) begin
         ack_reg   <= (shift_reg[7:1] == {`TARGET_ADDR_HI, addr_level});
         first_reg <= 1'b1;
      end else if (wr_take) begin
         ack_reg   <= first_reg ? is_mapped(rx_byte) : (ptr_reg == `OFS_PIN_ENABLES);
      end else if (scl_fall && state_reg == ST_WR_AK) begin
         first_reg <= 1'b0;
      end
   end

   // Register pointer: set by the first written byte, then stepped per data byte written and per read byte the host acknowledges
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ptr_reg <= `RST_BYTE;
      end else if (wr_take && first_reg) begin
         if (is_mapped(rx_byte)) begin
            ptr_reg <= rx_byte;
         end
      end else if (wr_take) begin
         ptr_reg <= ptr_reg + 8'h01;
      end else if (scl_rise && state_reg == ST_RD_AK && !sda_level) begin
         ptr_reg <= ptr_reg + 8'h01;
      end
   end

   // Transmit shifter and line drive
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tx_reg    <= `RST_BYTE;
         drive_reg <= 1'b0;
      end else if (start_det || stop_det) begin
         drive_reg <= 1'b0;
      end else if (rd_load) begin
         tx_reg    <= {rd_data[6:0], 1'b0};
         drive_reg <= ~rd_data[7];
      end else if (scl_fall) begin
         unique case (state_reg)
            ST_ADDR: begin
               drive_reg <= (bit_cnt_reg == `BIT_COUNT_FULL)
                            && (shift_reg[7:1] == {`TARGET_ADDR_HI, addr_level});
            end
            ST_WR_BYTE: begin
               drive_reg <= (bit_cnt_reg == `BIT_COUNT_FULL)
                            && (first_reg ? is_mapped(rx_byte)
                                          : (ptr_reg == `OFS_PIN_ENABLES));
            end
            ST_RD_BYTE: begin
               tx_reg    <= {tx_reg[6:0], 1'b0};
               drive_reg <= (bit_cnt_reg != `BIT_COUNT_FULL) && !tx_reg[7];
            end
            default:    drive_reg <= 1'b0;
         endcase
      end
   end

   // Enable register, the one writable location
   always_ff @(posedge mclk) begin
      if (sys_rst || clear_all) begin
         en_reg <= `RST_FLAGS;
      end else if (wr_take && !first_reg && ptr_reg == `OFS_PIN_ENABLES) begin
         en_reg <= rx_byte[`FLAG_MSB:`FLAG_LSB];
      end
   end

   // Humidity result held as raw code, RH% = code*100/65536
   always_ff @(posedge mclk) begin
      if (sys_rst || clear_all) begin
         hum_reg <= `RST_WORD;
      end else if (conv_done && hum_valid) begin
         hum_reg <= hum_result;
      end
   end

   // Flag set sources: completion and upper-byte threshold compares
   always_comb begin
      flag_set = `RST_FLAGS;
      flag_set[`BIT_DONE]      = conv_done;
      flag_set[`BIT_TEMP_HIGH] = conv_done & temp_valid & (temp_result[15:8] > temp_thr_high);
      flag_set[`BIT_TEMP_LOW]  = conv_done & temp_valid & (temp_result[15:8] < temp_thr_low);
      flag_set[`BIT_HUM_HIGH]  = conv_done & hum_valid & (hum_result[15:8] > hum_thr_high);
      flag_set[`BIT_HUM_LOW]   = conv_done & hum_valid & (hum_result[15:8] < hum_thr_low);
   end

   // Read-side clears: results or flags clear done, flags clear thresholds
   always_comb begin
      flag_clr = `RST_FLAGS;
      if (rd_load && ptr_reg <= `OFS_EVENT_FLAGS) begin
         flag_clr[`BIT_DONE] = 1'b1;
      end
      if (rd_load && ptr_reg == `OFS_EVENT_FLAGS) begin
         flag_clr[`BIT_TEMP_HIGH:`BIT_HUM_LOW] = 4'hF;
      end
   end

   // Sticky flags, set wins over clear, enables not involved
   always_ff @(posedge mclk) begin
      if (sys_rst || clear_all) begin
         flag_reg <= `RST_FLAGS;
      end else begin
         flag_reg <= (flag_reg & ~flag_clr) | flag_set;
      end
   end

   // Peak detectors on upper result bytes, one-shot mode only
   always_ff @(posedge mclk) begin
      if (sys_rst || clear_all) begin
         peak_temp_reg <= `RST_BYTE;
         peak_hum_reg  <= `RST_BYTE;
      end else if (conv_done && one_shot_mode) begin
         if (temp_valid && temp_result[15:8] > peak_temp_reg) begin
            peak_temp_reg <= temp_result[15:8];
         end
         if (hum_valid && hum_result[15:8] > peak_hum_reg) begin
            peak_hum_reg <= hum_result[15:8];
         end
      end
   end

   // Event pin: enabled flags ORed, gated by global enable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= event_pin_global_en & (|(flag_reg & en_reg));
      end
   end
   assign event_output_pin = irq_reg;

   // Checks next to the logic
   a_hum_capture: assert property (@(posedge mclk) disable iff (sys_rst)
      (conv_done && hum_valid && !soft_reset) |=> (hum_reg == $past(hum_result)))
      else $error("humidity result not captured");
   a_done_set: assert property (@(posedge mclk) disable iff (sys_rst)
      (conv_done && !soft_reset) |=> flag_reg[`BIT_DONE])
      else $error("done flag not set by conversion");
   a_status_clear: assert property (@(posedge mclk) disable iff (sys_rst)
      (rd_load && ptr_reg == `OFS_EVENT_FLAGS && !conv_done) |=> (flag_reg == `RST_FLAGS))
      else $error("flags not cleared by status read");
   a_thr_high_set: assert property (@(posedge mclk) disable iff (sys_rst)
      (conv_done && temp_valid && temp_result[15:8] > temp_thr_high && !soft_reset)
      |=> flag_reg[`BIT_TEMP_HIGH])
      else $error("temperature high flag missed");
   a_global_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      !event_pin_global_en |=> !event_output_pin)
      else $error("event pin active without global enable");
   a_source_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      ((flag_reg & en_reg) == `RST_FLAGS) |=> !event_output_pin)
      else $error("event pin active with no enabled flag");
   a_peak_rise: assert property (@(posedge mclk) disable iff (sys_rst)
      !soft_reset |=> (peak_temp_reg >= $past(peak_temp_reg)))
      else $error("peak temperature decreased");
   a_peak_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      (!one_shot_mode && !soft_reset) |=> $stable(peak_hum_reg))
      else $error("peak humidity moved outside one-shot mode");
   a_ro_nack: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_reg == ST_WR_AK && !first_reg && !ack_reg) |-> sda_oe_n)
      else $error("read-only data byte acknowledged");

endmodule // sensor_regs

// ===== sim/serial_host.sv
// Purpose: Bit-level model of the serial host that talks to the register port
// Assumes: Open-drain line with a pull-up resolved by the bench
// Notes:   Half period of 10 mclk; the bench calls the tasks by hierarchical name
`timescale 1ns/1ns
module serial_host
   import sensor_regs_pkg::*;
(
   // Clock
   input  wire logic mclk,
   // Resolved line level
   input  wire logic sda_line,
   // Host drives
   output logic      scl_pin,
   output logic      sda_low
);
   // Idle bus: clock high, line released
   initial begin
      scl_pin = 1'b1;
      sda_low = 1'b0;
   end

   // Half a serial period, stepping off the sampling edge
   task automatic half();
      repeat (10) @(posedge mclk);
      #2;
   endtask

   // Start, also used as repeated start from a low clock
   task automatic start_cond();
      sda_low = 1'b0;
      half();
      scl_pin = 1'b1;
      half();
      sda_low = 1'b1;
      half();
      scl_pin = 1'b0;
      half();
   endtask

   // Stop: line rises while the clock is high
   task automatic stop_cond();
      sda_low = 1'b1;
      half();
      scl_pin = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask

   // One bit out; the line only moves while the clock is low
   task automatic bit_tx(input logic b);
      sda_low = !b;
      half();
      scl_pin = 1'b1;
      half();
      scl_pin = 1'b0;
      half();
   endtask

   // One bit in, sampled at the end of the high phase
   task automatic bit_rx(output logic b);
      sda_low = 1'b0;
      half();
      scl_pin = 1'b1;
      half();
      b       = sda_line;
      scl_pin = 1'b0;
      half();
   endtask

   // Byte out MSB first, then the device's acknowledge
   task automatic send_byte(input byte_t d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_tx(d[i]);
      bit_rx(b);
      ack = (b === 1'b0);
   endtask

   // Byte in MSB first; the last byte is answered with a not-acknowledge
   task automatic recv_byte(input logic last, output byte_t d);
      for (int i = 7; i >= 0; i--) bit_rx(d[i]);
      bit_tx(last);
   endtask
endmodule // serial_host

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the sensor register block
// Assumes: Host model on the serial pins, bench acting as measurement engine
// Notes:   Table rows for conversions, hand tests for clears, refusals and resets
`timescale 1ns/1ns
`include "sensor_regs_cfg.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
   $display("[ERR] %s exp %h got %h", n, e, s); num_errors++; end end
module tb_top;
   import sensor_regs_pkg::*;

   typedef struct {
      byte_t       en, lo, hi, fl, pt, ph;
      logic        gen, os, pin;
      logic [15:0] t, h;
   } row_s;

   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        conv_done = 1'b0;
   logic        one_valid = 1'b1;
   logic        addr_sel = 1'b0;
   logic        one_shot_mode = 1'b1;
   logic        soft_reset = 1'b0;
   logic        gen = 1'b0;
   logic [15:0] temp_result = 16'h0000;
   logic [15:0] hum_result = 16'h0000;
   byte_t       thr_lo = 8'h20;
   byte_t       thr_hi = 8'hC0;
   logic        sda_in, sda_out, sda_oe_n, scl_pin, sda_low, event_output_pin, ak;
   byte_t       got [8];
   int          num_errors = 0;
   int          num_checks = 0;
   // Enables, thresholds, flags, peaks, global enable, one-shot, pin, results
   row_s        rows [6] = '{
      '{8'hF8, 8'h20, 8'hC0, 8'h80, 8'h80, 8'h40, 1'b1, 1'b1, 1'b1, 16'h8000, 16'h4012},
      '{8'h40, 8'h20, 8'hC0, 8'hC0, 8'hD0, 8'h40, 1'b1, 1'b1, 1'b1, 16'hD000, 16'h3034},
      '{8'h40, 8'h20, 8'hC0, 8'hB0, 8'hD0, 8'hE0, 1'b0, 1'b1, 1'b0, 16'h1000, 16'hE056},
      '{8'h08, 8'h20, 8'hC0, 8'hC8, 8'hD0, 8'hE0, 1'b1, 1'b0, 1'b1, 16'hF000, 16'h1078},
      '{8'h20, 8'h20, 8'hC0, 8'h80, 8'hD0, 8'hE0, 1'b1, 1'b1, 1'b0, 16'h5000, 16'h509A},
      '{8'h00, 8'h20, 8'hE0, 8'h80, 8'hE0, 8'hE0, 1'b1, 1'b1, 1'b0, 16'hE000, 16'hE0BC}};

   // Clock and open-drain line with pull-up
   always #20 mclk = ~mclk;
   assign sda_in = sda_low ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);

   sensor_regs i_sensor_regs (
      .mclk(mclk), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .addr_pin(addr_sel), .conv_done(conv_done), .temp_valid(one_valid),
      .hum_valid(one_valid), .temp_result(temp_result), .hum_result(hum_result),
      .one_shot_mode(one_shot_mode), .soft_reset(soft_reset), .temp_thr_low(thr_lo),
      .temp_thr_high(thr_hi), .hum_thr_low(thr_lo), .hum_thr_high(thr_hi),
      .event_pin_global_en(gen), .event_output_pin(event_output_pin));

   serial_host i_serial_host (.mclk(mclk), .sda_line(sda_in), .scl_pin(scl_pin), .sda_low(sda_low));

   // Cycles, stepping off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   // Start, write address, pointer byte
   task automatic addr_ptr(input byte_t p, input logic pk);
      i_serial_host.start_cond();
      i_serial_host.send_byte({`TARGET_ADDR_HI, addr_sel, 1'b0}, ak);
      `CHK("addr ack", 1'b1, ak)
      i_serial_host.send_byte(p, ak);
      `CHK("ptr ack", pk, ak)
   endtask

   // Write n bytes from the top of d, expecting the given acknowledges
   task automatic wr(input byte_t p, input logic [15:0] d, input int n, input logic [1:0] dk);
      addr_ptr(p, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_serial_host.send_byte(d[15-8*i -: 8], ak);
         `CHK("data ack", dk[1-i], ak)
      end
      i_serial_host.stop_cond();
   endtask

   // Set the pointer, then read n bytes after a repeated start
   task automatic rd(input byte_t p, input int n);
      addr_ptr(p, 1'b1);
      i_serial_host.start_cond();
      i_serial_host.send_byte({`TARGET_ADDR_HI, addr_sel, 1'b1}, ak);
      `CHK("rd addr ack", 1'b1, ak)
      for (int i = 0; i < n; i++) i_serial_host.recv_byte(i == n - 1, got[i]);
      i_serial_host.stop_cond();
   endtask

   // One conversion pulse from the measurement engine
   task automatic conv(input logic [15:0] t, input logic [15:0] h);
      temp_result = t;
      hum_result  = h;
      conv_done   = 1'b1;
      cyc(1);
      conv_done   = 1'b0;
      cyc(3);
   endtask

   // Every byte from 0x02 to 0x07 reads zero
   task automatic all_zero();
      rd(8'h02, 6);
      for (int i = 0; i < 6; i++) `CHK("zero byte", 8'h00, got[i])
   endtask

   // Verdict and end of run
   task automatic close_out();
      if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Main sequence
   initial begin
      cyc(6);
      sys_rst = 1'b0;
      cyc(2);
      all_zero();
      `CHK("pin reset", 1'b0, event_output_pin)
      // Conversion table
      foreach (rows[r]) begin
         wr(8'h07, {rows[r].en, 8'h00}, 1, 2'b10);
         gen           = rows[r].gen;
         one_shot_mode = rows[r].os;
         thr_lo        = rows[r].lo;
         thr_hi        = rows[r].hi;
         conv(rows[r].t, rows[r].h);
         `CHK("pin", rows[r].pin, event_output_pin)
         rd(8'h04, 4);
         `CHK("flags", rows[r].fl, got[0])
         `CHK("peak t", rows[r].pt, got[1])
         `CHK("peak h", rows[r].ph, got[2])
         `CHK("enables", rows[r].en, got[3])
         `CHK("pin clear", 1'b0, event_output_pin)
         rd(8'h02, 2);
         `CHK("hum low", rows[r].h[7:0], got[0])
         `CHK("hum high", rows[r].h[15:8], got[1])
      end
      // Reading any result byte clears the done flag
      thr_lo = 8'h00;
      thr_hi = 8'hFF;
      for (int p = 0; p < 4; p++) begin
         conv(16'hC3A5, 16'h5A3C);
         rd(p[7:0], 1);
         `CHK("result byte", 32'h5A3CC3A5 >> (8 * p) & 8'hFF, {24'h0, got[0]})
         rd(8'h04, 1);
         `CHK("done cleared", 8'h00, got[0])
      end
      // Threshold flags survive a result read, the status read clears them
      thr_hi = 8'h10;
      conv(16'hC3A5, 16'h5A3C);
      rd(8'h02, 3);
      `CHK("flags kept", 8'h50, got[2])
      rd(8'h04, 1);
      `CHK("flags gone", 8'h00, got[0])
      // Unqualified results set only the done flag and leave the peaks alone
      one_valid = 1'b0;
      conv(16'hFFFF, 16'hFFFF);
      one_valid = 1'b1;
      rd(8'h04, 3);
      `CHK("done only", 8'h80, got[0])
      `CHK("peak t kept", 8'hE0, got[1])
      `CHK("peak h kept", 8'hE0, got[2])
      // Write into a read-only byte is refused, the pointer still moves on
      wr(8'h06, 16'h55F0, 2, 2'b01);
      rd(8'h06, 2);
      `CHK("peak kept", 8'hE0, got[0])
      `CHK("enables next", 8'hF0, got[1])
      // Other address pin level: old address refused, unused pointer refused and not taken
      addr_sel = 1'b1;
      i_serial_host.start_cond();
      i_serial_host.send_byte({`TARGET_ADDR_HI, 2'b00}, ak);
      `CHK("wrong addr", 1'b0, ak)
      i_serial_host.stop_cond();
      addr_ptr(8'h08, 1'b0);
      i_serial_host.stop_cond();
      i_serial_host.start_cond();
      i_serial_host.send_byte({`TARGET_ADDR_HI, 2'b11}, ak);
      i_serial_host.recv_byte(1'b1, got[0]);
      i_serial_host.stop_cond();
      `CHK("ptr kept", 8'hF0, got[0])
      // Reset in mid-run with the pin raised
      conv(16'hC3A5, 16'h5A3C);
      `CHK("pin set", 1'b1, event_output_pin)
      sys_rst = 1'b1;
      cyc(6);
      sys_rst = 1'b0;
      cyc(2);
      `CHK("pin after reset", 1'b0, event_output_pin)
      all_zero();
      // Software reset clears the humidity result, flags, peaks and enables
      wr(8'h07, 16'hF800, 1, 2'b10);
      conv(16'hC3A5, 16'h5A3C);
      soft_reset = 1'b1;
      cyc(1);
      soft_reset = 1'b0;
      cyc(2);
      all_zero();
      close_out();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(90000 * 40);
      num_errors++;
      close_out();
   end
endmodule // tb_top
